// file: src/l1dc_cache.sv
// Purpose: two-way write-back level1_data_cache with slave_dma_port to level-2 RAM
// Assumes: requesters hold req and operands until their ack pulse
// Notes:   one controller serialises line traffic and DMA on the level-2 port
// Functional notes
// RULE_01: Two ways per set, one set per address.
// RULE_02: Lines are 64 bytes, moved whole.
// RULE_03: Only CPU read misses allocate lines.
// RULE_04: CPU write hit updates line, marks dirty.
// RULE_05: Dirty data leaves only on eviction or flush.
// RULE_06: Dirty victim written back before new fill.
// RULE_07: DMA never interleaves with victim or fill.
// RULE_08: Software aligns unshared buffers to 64 bytes.
// RULE_09: Software flushes shared buffers before DMA use.
// RULE_10: All-cache level-2 refuses slave DMA accesses.
// RULE_11: Victims go to the level-2 port.
// RULE_12: Least recently used way is replaced.
`timescale 1ns/10ps
`include "l1dc_map.svh"
module l1dc_cache
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// CPU load/store
	input  wire logic                cpu_req,
	input  wire logic                cpu_we,
	input  wire l1dc_pkg::l1dc_addr_t cpu_addr,
	input  wire l1dc_pkg::l1dc_word_t cpu_wdata,
	output      logic                cpu_ack,
	output      l1dc_pkg::l1dc_word_t cpu_rdata,
	// Explicit line write-back
	input  wire logic                wb_req,
	input  wire l1dc_pkg::l1dc_addr_t wb_addr,
	output      logic                wb_done,
	// Slave DMA port
	input  wire logic                dma_req,
	input  wire logic                dma_we,
	input  wire l1dc_pkg::l1dc_addr_t dma_addr,
	input  wire l1dc_pkg::l1dc_word_t dma_wdata,
	output      logic                dma_ack,
	output      logic                dma_err,
	output      l1dc_pkg::l1dc_word_t dma_rdata,
	// Configuration
	input  wire logic                l2_all_cache,
	// Level-2 RAM
	output      logic                l2_req,
	output      logic                l2_we,
	output      l1dc_pkg::l1dc_addr_t l2_addr,
	output      l1dc_pkg::l1dc_word_t l2_wdata,
	input  wire l1dc_pkg::l1dc_word_t l2_rdata,
	input  wire logic                l2_ack
);
	import l1dc_pkg::*;

	l1dc_state_t st_q;
	logic [3:0]  cnt_q;
	logic        way_q;
	logic        flush_q;
	l1dc_addr_t  line_q;
	l1dc_addr_t  fill_q;
	logic        cpu_ack_q, wb_done_q, dma_ack_q, dma_err_q;
	l1dc_word_t  cpu_rdata_q, dma_rdata_q;
	logic        l2_req_q, l2_we_q;
	l1dc_addr_t  l2_addr_q;
	l1dc_word_t  l2_wdata_q;

	l1dc_word_t  mem_q   [0:`L1DC_LINES-1][0:`L1DC_WORDS-1];
	l1dc_tag_t   tag_q   [0:`L1DC_LINES-1];
	logic [`L1DC_LINES-1:0] valid_q;
	logic [`L1DC_LINES-1:0] dirty_q;
	logic [`L1DC_SETS-1:0]  lru_q;

	logic [1:0]  cpu_hv, dma_hv, wb_hv;
	logic        go_dma, go_wb, go_cpu, vic_way, last_w;
	logic [2:0]  cpu_li, dma_li, wb_li, vic_li, cur_li;

	function automatic logic [1:0] set_of(input l1dc_addr_t a);
		set_of = a[`L1DC_IDX_MSB:`L1DC_IDX_LSB];
	endfunction

	// One hit bit per way of the addressed set
	function automatic logic [1:0] hit_vec(input l1dc_addr_t a);
		logic [1:0] h;
		h = 2'h0;
		for (int w = 0; w < 2; w++)
		begin
			h[w] = valid_q[{w[0], set_of(a)}] && (tag_q[{w[0], set_of(a)}] == a[31:`L1DC_TAG_LSB]); // RULE_01
		end
		hit_vec = h;
	endfunction

	function automatic l1dc_addr_t word_addr(input l1dc_addr_t base, input logic [3:0] w);
		word_addr = {base[31:`L1DC_IDX_LSB], w, 2'h0}; // RULE_02
	endfunction

	always_comb
	begin
		cpu_hv  = hit_vec(cpu_addr);
		dma_hv  = hit_vec(dma_addr);
		wb_hv   = hit_vec(wb_addr);
		cpu_li  = {cpu_hv[1], set_of(cpu_addr)};
		dma_li  = {dma_hv[1], set_of(dma_addr)};
		wb_li   = {wb_hv[1], set_of(wb_addr)};
		// Prefer an empty way, else the least recently used one
		vic_way = !valid_q[{1'b0, set_of(cpu_addr)}] ? 1'b0 :
			(!valid_q[{1'b1, set_of(cpu_addr)}] ? 1'b1 : lru_q[set_of(cpu_addr)]); // RULE_12
		vic_li  = {vic_way, set_of(cpu_addr)};
		cur_li  = {way_q, set_of(line_q)};
		last_w  = (cnt_q == `L1DC_LAST_WORD);
		go_dma  = (st_q == ST_IDLE) && dma_req && !dma_ack_q;
		go_wb   = (st_q == ST_IDLE) && wb_req && !wb_done_q && !go_dma;
		go_cpu  = (st_q == ST_IDLE) && cpu_req && !cpu_ack_q && !go_dma && !go_wb;
	end

	// Controller and level-2 port
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_q        <= ST_IDLE;
			cnt_q       <= 4'h0;
			way_q       <= 1'b0;
			flush_q     <= 1'b0;
			line_q      <= 32'h0;
			fill_q      <= 32'h0;
			cpu_ack_q   <= 1'b0;
			wb_done_q   <= 1'b0;
			dma_ack_q   <= 1'b0;
			dma_err_q   <= 1'b0;
			cpu_rdata_q <= 32'h0;
			dma_rdata_q <= 32'h0;
			l2_req_q    <= 1'b0;
			l2_we_q     <= 1'b0;
			l2_addr_q   <= 32'h0;
			l2_wdata_q  <= 32'h0;
		end
		else
		begin
			cpu_ack_q <= 1'b0;
			wb_done_q <= 1'b0;
			dma_ack_q <= 1'b0;
			dma_err_q <= 1'b0;
			case (st_q)
				ST_IDLE:
				begin
					if (go_dma)
					begin
						if (l2_all_cache)
						begin
							dma_ack_q <= 1'b1; // RULE_10
							dma_err_q <= 1'b1; // RULE_10
						end
						else if (!dma_we && (|dma_hv) && dirty_q[dma_li])
						begin
							// Newest copy lives in the cache
							dma_rdata_q <= mem_q[dma_li][dma_addr[`L1DC_OFS_MSB:`L1DC_WRD_LSB]]; // RULE_07
							dma_ack_q   <= 1'b1;
						end
						else
						begin
							st_q       <= ST_DMA;
							l2_req_q   <= 1'b1;
							l2_we_q    <= dma_we;
							l2_addr_q  <= {dma_addr[31:2], 2'h0};
							l2_wdata_q <= dma_wdata;
						end
					end
					else if (go_wb)
					begin
						if ((|wb_hv) && dirty_q[wb_li])
						begin
							way_q      <= wb_hv[1];
							line_q     <= word_addr(wb_addr, 4'h0);
							flush_q    <= 1'b1;
							st_q       <= ST_EVICT; // RULE_05
							l2_req_q   <= 1'b1;
							l2_we_q    <= 1'b1;
							l2_addr_q  <= word_addr(wb_addr, 4'h0);
							l2_wdata_q <= mem_q[wb_li][0];
						end
						else
						begin
							wb_done_q <= 1'b1;
						end
					end
					else if (go_cpu)
					begin
						if (|cpu_hv)
						begin
							cpu_ack_q   <= 1'b1;
							cpu_rdata_q <= mem_q[cpu_li][cpu_addr[`L1DC_OFS_MSB:`L1DC_WRD_LSB]];
						end
						else if (cpu_we)
						begin
							// Write miss goes around the cache
							st_q       <= ST_WMISS; // RULE_03
							l2_req_q   <= 1'b1;
							l2_we_q    <= 1'b1;
							l2_addr_q  <= {cpu_addr[31:2], 2'h0};
							l2_wdata_q <= cpu_wdata;
						end
						else
						begin
							way_q   <= vic_way;
							fill_q  <= word_addr(cpu_addr, 4'h0);
							flush_q <= 1'b0;
							l2_req_q <= 1'b1;
							if (valid_q[vic_li] && dirty_q[vic_li])
							begin
								st_q       <= ST_EVICT; // RULE_06
								line_q     <= {tag_q[vic_li], set_of(cpu_addr), 6'h00};
								l2_we_q    <= 1'b1;
								l2_addr_q  <= {tag_q[vic_li], set_of(cpu_addr), 6'h00};
								l2_wdata_q <= mem_q[vic_li][0];
							end
							else
							begin
								st_q      <= ST_FILL; // RULE_03
								line_q    <= word_addr(cpu_addr, 4'h0);
								l2_we_q   <= 1'b0;
								l2_addr_q <= word_addr(cpu_addr, 4'h0);
							end
						end
					end
				end
				ST_EVICT:
				begin
					if (l2_ack)
					begin
						if (last_w)
						begin
							cnt_q <= 4'h0;
							if (flush_q)
							begin
								st_q      <= ST_IDLE;
								l2_req_q  <= 1'b0;
								wb_done_q <= 1'b1;
							end
							else
							begin
								// Fill follows the victim on the same port
								st_q      <= ST_FILL; // RULE_11
								l2_we_q   <= 1'b0;
								l2_addr_q <= fill_q;
							end
						end
						else
						begin
							cnt_q      <= cnt_q + 4'h1;
							l2_addr_q  <= word_addr(line_q, cnt_q + 4'h1); // RULE_02
							l2_wdata_q <= mem_q[cur_li][cnt_q + 4'h1];
						end
					end
				end
				ST_FILL:
				begin
					if (l2_ack)
					begin
						if (last_w)
						begin
							cnt_q    <= 4'h0;
							st_q     <= ST_IDLE;
							l2_req_q <= 1'b0;
						end
						else
						begin
							cnt_q     <= cnt_q + 4'h1;
							l2_addr_q <= word_addr(fill_q, cnt_q + 4'h1);
						end
					end
				end
				ST_WMISS:
				begin
					if (l2_ack)
					begin
						st_q      <= ST_IDLE;
						l2_req_q  <= 1'b0;
						cpu_ack_q <= 1'b1;
					end
				end
				ST_DMA:
				begin
					if (l2_ack)
					begin
						st_q        <= ST_IDLE;
						l2_req_q    <= 1'b0;
						dma_ack_q   <= 1'b1;
						dma_rdata_q <= l2_rdata;
					end
				end
				default:
				begin
					st_q     <= ST_IDLE;
					l2_req_q <= 1'b0;
				end
			endcase
		end
	end

	// Line storage
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			valid_q <= 8'h00;
			dirty_q <= 8'h00;
			lru_q   <= 4'h0;
		end
		else
		begin
			if (go_cpu && (|cpu_hv))
			begin
				lru_q[set_of(cpu_addr)] <= ~cpu_hv[1]; // RULE_12
				if (cpu_we)
				begin
					mem_q[cpu_li][cpu_addr[`L1DC_OFS_MSB:`L1DC_WRD_LSB]] <= cpu_wdata; // RULE_04
					dirty_q[cpu_li] <= 1'b1; // RULE_04
				end
			end
			if ((st_q == ST_FILL) && l2_ack)
			begin
				mem_q[cur_li][cnt_q] <= l2_rdata;
				if (last_w)
				begin
					tag_q[cur_li]          <= fill_q[31:`L1DC_TAG_LSB];
					valid_q[cur_li]        <= 1'b1;
					dirty_q[cur_li]        <= 1'b0;
					lru_q[set_of(line_q)]  <= ~way_q;
				end
			end
			if ((st_q == ST_EVICT) && l2_ack && last_w && flush_q)
			begin
				dirty_q[cur_li] <= 1'b0; // RULE_09
			end
			// Keep the cached copy in step with DMA writes
			if ((st_q == ST_DMA) && l2_ack && l2_we_q && (|dma_hv))
			begin
				mem_q[dma_li][dma_addr[`L1DC_OFS_MSB:`L1DC_WRD_LSB]] <= dma_wdata; // RULE_07
			end
		end
	end

	assign cpu_ack   = cpu_ack_q;
	assign cpu_rdata = cpu_rdata_q;
	assign wb_done   = wb_done_q;
	assign dma_ack   = dma_ack_q;
	assign dma_err   = dma_err_q;
	assign dma_rdata = dma_rdata_q;
	assign l2_req    = l2_req_q;
	assign l2_we     = l2_we_q;
	assign l2_addr   = l2_addr_q;
	assign l2_wdata  = l2_wdata_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence rd_miss_s;
		go_cpu && !cpu_we && !(|cpu_hv);
	endsequence
	sequence dirty_vic_s;
		rd_miss_s ##0 (valid_q[vic_li] && dirty_q[vic_li]);
	endsequence

	one_way_hit_a: assert property (go_cpu |-> cpu_hv != 2'h3) // RULE_01
		else $error("address hits both ways");
	line_word_a: assert property (((st_q == ST_EVICT) || (st_q == ST_FILL)) && l2_req_q
		|-> l2_addr_q[`L1DC_OFS_MSB:0] == {cnt_q, 2'h0}) // RULE_02
		else $error("line burst word out of step");
	wr_no_alloc_a: assert property (go_cpu && cpu_we && !(|cpu_hv)
		|=> (st_q == ST_WMISS) && $stable(valid_q)) // RULE_03
		else $error("write miss allocated a line");
	hit_dirty_a: assert property (go_cpu && cpu_we && (|cpu_hv)
		|=> cpu_ack_q && dirty_q[$past(cpu_li)]) // RULE_04
		else $error("write hit not marked dirty");
	wr_source_a: assert property (l2_req_q && l2_we_q |-> st_q != ST_FILL) // RULE_05
		else $error("level-2 write during fill");
	victim_first_a: assert property (dirty_vic_s |=> (st_q == ST_EVICT) && l2_we_q
		&& l2_addr_q == $past({tag_q[vic_li], set_of(cpu_addr), 6'h00})) // RULE_06 RULE_11
		else $error("dirty victim not written back");
	dma_excl_a: assert property (((st_q == ST_EVICT) || (st_q == ST_FILL)) |=> !dma_ack_q) // RULE_07
		else $error("DMA answered during line move");
	all_cache_a: assert property (go_dma && l2_all_cache |=> dma_ack_q && dma_err_q
		&& st_q == ST_IDLE) // RULE_10
		else $error("DMA not refused when level-2 is all cache");
	lru_pick_a: assert property (rd_miss_s ##0 (&{valid_q[{1'b0, set_of(cpu_addr)}],
		valid_q[{1'b1, set_of(cpu_addr)}]}) |=> way_q == $past(lru_q[set_of(cpu_addr)])) // RULE_12
		else $error("victim is not the LRU way");
endmodule // l1dc_cache

// file: src/l1dc_map.svh
// Purpose: constants for the level-1 data cache
// Assumes: 32-bit byte addresses, 32-bit words
// Notes:   geometry and address field positions
`ifndef L1DC_MAP_SVH
`define L1DC_MAP_SVH
`define L1DC_LINE_BYTES 64
`define L1DC_SETS       4
`define L1DC_LINES      8
`define L1DC_WORDS      16
`define L1DC_OFS_MSB    5
`define L1DC_WRD_LSB    2
`define L1DC_IDX_LSB    6
`define L1DC_IDX_MSB    7
`define L1DC_TAG_LSB    8
`define L1DC_LAST_WORD  4'hF
`endif

// file: src/l1dc_pkg.sv
// Purpose: types for the level-1 data cache
// Assumes: constants in l1dc_map.svh
// Notes:   state codes written out
package l1dc_pkg;
	typedef logic [31:0] l1dc_word_t;
	typedef logic [31:0] l1dc_addr_t;
	typedef logic [23:0] l1dc_tag_t;
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h0,
		ST_EVICT = 3'h1,
		ST_FILL  = 3'h2,
		ST_WMISS = 3'h3,
		ST_DMA   = 3'h4
	} l1dc_state_t;
endpackage

// file: verif/l1dc_cache_tb.sv
// Purpose: self-checking bench for the level1_data_cache
// Assumes: level-2 model answers every word request
// Notes:   buffers kept on 64-byte lines, flushed before DMA use except in t_victim_dma
`timescale 1ns/10ps
module l1dc_cache_tb;
	import l1dc_pkg::*;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic       cpu_req = 1'b0;
	logic       cpu_we = 1'b0;
	l1dc_addr_t cpu_addr = 32'h0;
	l1dc_word_t cpu_wdata = 32'h0;
	logic       wb_req = 1'b0;
	l1dc_addr_t wb_addr = 32'h0;
	logic       dma_req = 1'b0;
	logic       dma_we = 1'b0;
	l1dc_addr_t dma_addr = 32'h0;
	l1dc_word_t dma_wdata = 32'h0;
	logic       l2_all_cache = 1'b0;
	logic [3:0] dly = 4'h0;
	logic       cpu_ack, wb_done, dma_ack, dma_err, l2_req, l2_we, l2_ack;
	l1dc_word_t cpu_rdata, dma_rdata, l2_wdata, l2_rdata;
	l1dc_addr_t l2_addr;
	int         errors = 0;
	int         checked = 0;

	always #50 ref_clk = ~ref_clk;

	l1dc_cache u_dut (.ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req), .cpu_we(cpu_we),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
		.wb_req(wb_req), .wb_addr(wb_addr), .wb_done(wb_done), .dma_req(dma_req),
		.dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
		.dma_err(dma_err), .dma_rdata(dma_rdata), .l2_all_cache(l2_all_cache),
		.l2_req(l2_req), .l2_we(l2_we), .l2_addr(l2_addr), .l2_wdata(l2_wdata),
		.l2_rdata(l2_rdata), .l2_ack(l2_ack));
	l1dc_l2_model u_l2 (.ref_clk(ref_clk), .rst(rst), .l2_req(l2_req), .l2_we(l2_we),
		.l2_addr(l2_addr), .l2_wdata(l2_wdata), .l2_rdata(l2_rdata), .l2_ack(l2_ack),
		.dly(dly));

	function automatic logic [31:0] ini(input logic [31:0] a);
		return 32'h5A000000 + {24'h0, a[9:2]};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Waits for ack of cpu (0), flush (1) or dma (2)
	task automatic hold(input int k);
		int n;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while ((k == 0 ? cpu_ack : k == 1 ? wb_done : dma_ack) !== 1'b1 && n < 3000);
		if (n >= 3000)
			chk("ack wait", 32'h1, 32'h0);
	endtask
	task automatic cpu(input logic we, input l1dc_addr_t a, input l1dc_word_t d,
		output l1dc_word_t q);
		cpu_we <= we;
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_req <= 1'b1;
		hold(0);
		q = cpu_rdata;
		@(posedge ref_clk);
		cpu_req <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic flush(input l1dc_addr_t a);
		wb_addr <= a;
		wb_req <= 1'b1;
		hold(1);
		@(posedge ref_clk);
		wb_req <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic dma(input logic we, input l1dc_addr_t a, input l1dc_word_t d,
		output l1dc_word_t q, output logic e);
		dma_we <= we;
		dma_addr <= a;
		dma_wdata <= d;
		dma_req <= 1'b1;
		hold(2);
		q = dma_rdata;
		e = dma_err;
		@(posedge ref_clk);
		dma_req <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic t_fill();
		l1dc_word_t q;
		int r;
		r = u_l2.rd_cnt;
		cpu(1'b0, 32'h104, 32'h0, q);
		chk("miss data", ini(32'h104), q);
		chk("fill words", 16, u_l2.rd_cnt - r);
		cpu(1'b0, 32'h13C, 32'h0, q);
		chk("hit data", ini(32'h13C), q);
		cpu(1'b1, 32'h104, 32'hD1D1D1D1, q);
		chk("l2 untouched", ini(32'h104), u_l2.mem[8'h41]);
		cpu(1'b0, 32'h104, 32'h0, q);
		chk("dirty data", 32'hD1D1D1D1, q);
		chk("no refill", 16, u_l2.rd_cnt - r);
		cpu(1'b1, 32'h0C0, 32'h0BADF00D, q);
		chk("write around", 32'h0BADF00D, u_l2.mem[8'h30]);
		cpu(1'b0, 32'h0C0, 32'h0, q);
		chk("no write alloc", 32, u_l2.rd_cnt - r);
		$display("Test fill done");
	endtask
	task automatic t_evict();
		l1dc_word_t q;
		int r;
		int w;
		dly <= 4'h3;
		w = u_l2.wr_cnt;
		cpu(1'b0, 32'h200, 32'h0, q);
		cpu(1'b0, 32'h104, 32'h0, q);
		cpu(1'b0, 32'h300, 32'h0, q);
		chk("lru victim", 0, u_l2.wr_cnt - w);
		cpu(1'b0, 32'h300, 32'h0, q);
		r = u_l2.rd_cnt;
		cpu(1'b0, 32'h000, 32'h0, q);
		chk("victim words", 16, u_l2.wr_cnt - w);
		chk("victim data", 32'hD1D1D1D1, u_l2.mem[8'h41]);
		chk("new line", ini(32'h000), q);
		cpu(1'b0, 32'h104, 32'h0, q);
		chk("reload", 32'hD1D1D1D1, q);
		chk("reload words", 32, u_l2.rd_cnt - r);
		dly <= 4'h0;
		$display("Test evict done");
	endtask
	task automatic t_flush();
		l1dc_word_t q;
		int w;
		cpu(1'b0, 32'h140, 32'h0, q);
		cpu(1'b1, 32'h144, 32'hFEEDC0DE, q);
		w = u_l2.wr_cnt;
		flush(32'h17C);
		chk("flush words", 16, u_l2.wr_cnt - w);
		chk("flush data", 32'hFEEDC0DE, u_l2.mem[8'h51]);
		flush(32'h140);
		chk("clean flush", 16, u_l2.wr_cnt - w);
		$display("Test flush done");
	endtask
	task automatic t_dma();
		l1dc_word_t q;
		logic e;
		int r;
		r = u_l2.rd_cnt;
		dma(1'b1, 32'h148, 32'h600DCAFE, q, e);
		chk("dma err", 0, e);
		chk("dma l2 write", 32'h600DCAFE, u_l2.mem[8'h52]);
		cpu(1'b0, 32'h148, 32'h0, q);
		chk("cache copy", 32'h600DCAFE, q);
		chk("cache hit", 0, u_l2.rd_cnt - r);
		dma(1'b0, 32'h148, 32'h0, q, e);
		chk("dma read", 32'h600DCAFE, q);
		l2_all_cache <= 1'b1;
		dma(1'b1, 32'h180, 32'h11111111, q, e);
		chk("all cache err", 1, e);
		chk("refused write", ini(32'h180), u_l2.mem[8'h60]);
		l2_all_cache <= 1'b0;
		$display("Test dma done");
	endtask
	// DMA to victim raised while the victim moves, then DMA to the new line
	task automatic t_victim_dma();
		l1dc_word_t q;
		l1dc_word_t p;
		logic e;
		cpu(1'b0, 32'h080, 32'h0, q);
		cpu(1'b1, 32'h084, 32'h12345678, q);
		cpu(1'b0, 32'h280, 32'h0, q);
		fork
			cpu(1'b0, 32'h380, 32'h0, q);
			begin
				repeat (4) @(posedge ref_clk);
				dma(1'b1, 32'h088, 32'hAAAA5555, p, e);
				dma(1'b1, 32'h384, 32'h5555AAAA, p, e);
			end
		join
		chk("victim word", 32'h12345678, u_l2.mem[8'h21]);
		chk("dma on victim", 32'hAAAA5555, u_l2.mem[8'h22]);
		chk("dma on new l2", 32'h5555AAAA, u_l2.mem[8'hE1]);
		cpu(1'b0, 32'h384, 32'h0, q);
		chk("dma on new line", 32'h5555AAAA, q);
		$display("Test victim dma done");
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_fill();
		t_evict();
		t_flush();
		t_dma();
		t_victim_dma();
		final_report();
	end
	// Whole run needs well under 30000 cycles
	initial
	begin
		#3000000;
		errors++;
		final_report();
	end
endmodule // l1dc_cache_tb

// file: verif/l1dc_l2_model.sv
// Purpose: level-2 RAM behind the cache
// Assumes: each word request held until its ack
// Notes:   dly sets answer latency; counts reads and writes
`timescale 1ns/10ps
module l1dc_l2_model
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Level-2 port
	input  wire logic        l2_req,
	input  wire logic        l2_we,
	input  wire logic [31:0] l2_addr,
	input  wire logic [31:0] l2_wdata,
	output      logic [31:0] l2_rdata,
	output      logic        l2_ack,
	// Latency
	input  wire logic [3:0]  dly
);
	logic [31:0] mem [256];
	logic [3:0]  wait_q = 4'h0;
	int          rd_cnt = 0;
	int          wr_cnt = 0;
	initial
	begin
		l2_ack = 1'b0;
		l2_rdata = 32'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 32'h5A000000 + i;
	end
	// Data toggles except on read acks so stale words never match
	always @(posedge ref_clk)
	begin
		l2_ack <= 1'b0;
		l2_rdata <= ~l2_rdata;
		if (rst || !l2_req || l2_ack)
			wait_q <= 4'h0;
		else if (wait_q != dly)
			wait_q <= wait_q + 4'h1;
		else
		begin
			l2_ack <= 1'b1;
			if (l2_we)
			begin
				mem[l2_addr[9:2]] <= l2_wdata;
				wr_cnt <= wr_cnt + 1;
			end
			else
			begin
				l2_rdata <= mem[l2_addr[9:2]];
				rd_cnt <= rd_cnt + 1;
			end
		end
	end
endmodule // l1dc_l2_model
